// >>> pkg/ebsu_map.svh
// Constants for the execute, branch and skip unit
// Overview of operation
// - Set bits: OR mask, flags Z N V, 1 cycle
// - Clear bits: AND inverted mask, Z N V
// - Test: AND with itself, Z N V
// - Relative jump/call: PC+k+1, 2/3 cycles
// - Pointer jump: PC from Z, 2 cycles
// - Pointer call: PC from Z, 3 cycles
// - Compare-skip-equal skips next, no flags
// - Compares subtract, set Z N V C H
// - Skip on register bit clear or set
// - Skip on I/O bit clear or set
// - Generic flag branch on selected flag bit
// - Signed branches test N xor V
// - Unsigned use C, equal Z, sign N
// - Half-carry branches test H
// - Transfer-bit branches test T
// - Overflow branches test V
// - Interrupt-state branches test I
// - Load via X in 2 cycles, optional post-increment
`ifndef EBSU_MAP_SVH
`define EBSU_MAP_SVH
`define EBSU_FLAG_C 3'h0
`define EBSU_FLAG_Z 3'h1
`define EBSU_FLAG_N 3'h2
`define EBSU_FLAG_V 3'h3
`define EBSU_FLAG_S 3'h4
`define EBSU_FLAG_H 3'h5
`define EBSU_FLAG_T 3'h6
`define EBSU_FLAG_I 3'h7
`define EBSU_CYC_ONE 2'h1
`define EBSU_CYC_TWO 2'h2
`define EBSU_CYC_THREE 2'h3
`define EBSU_FLAGS_RST 8'h00
`endif

// >>> pkg/ebsu_pkg.sv
// Types for the execute, branch and skip unit
package ebsu_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_TEST_ZERO_MINUS,
    OP_RELATIVE_JUMP, OP_RELATIVE_SUBCALL, OP_POINTER_JUMP, OP_POINTER_CALL,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_LOAD_INDIRECT, OP_LOAD_INDIRECT_INC
  } ebsu_op_t;

  // One decoded instruction with its operands
  typedef struct packed {
    ebsu_op_t    op;
    logic [7:0]  opA;
    logic [7:0]  opB;
    logic [7:0]  ioValue;
    logic [2:0]  bitSel;
    logic [11:0] offset;
    logic        nextIsTwoWord;
  } ebsu_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} ebsu_state_t;
endpackage

// >>> rtl/ebsu_exec_unit.sv
// Execute stage for logic, compare, branch, skip and indirect load
`timescale 1ns/10ps
`include "ebsu_map.svh"
module ebsu_exec_unit #(
  parameter int PC_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              reqValid,
  input  ebsu_pkg::ebsu_req_t    req,
  input  wire logic [PC_W-1:0]   pcIn,
  input  wire logic [15:0]       zPointer,
  input  wire logic [15:0]       xPointer,
  input  wire logic [7:0]        memData,
  output logic                   busy,
  output logic                   done,
  output logic [PC_W-1:0]        pcOut,
  output logic                   pcLoad,
  output logic                   pushReturn,
  output logic [7:0]             result,
  output logic                   resultWrite,
  output logic [7:0]             flags,
  output logic [15:0]            memAddr,
  output logic                   memRead,
  output logic [15:0]            xNext,
  output logic                   xWrite
);
  import ebsu_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [PC_W-1:0] relTarget(input logic [PC_W-1:0] pc,
                                                input logic [11:0] k);
    logic [PC_W-1:0] ext;
    ext = PC_W'(signed'(k));
    return pc + ext + PC_W'(1);
  endfunction

  function automatic logic [7:0] logicFlags(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[`EBSU_FLAG_Z] = (r == 8'h00);
    o[`EBSU_FLAG_N] = r[7];
    o[`EBSU_FLAG_V] = 1'b0;
    o[`EBSU_FLAG_S] = r[7];
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Combinational execute
  // ----------------------------------------------------------------
  logic [7:0]      aluRes;
  logic [7:0]      nextFlags;
  logic            writeRes;
  logic            taken;
  logic            skip;
  logic [PC_W-1:0] target;
  logic [1:0]      cycles;
  logic [8:0]      diff;
  logic [7:0]      subB;
  logic            cin;

  always_comb begin
    aluRes    = 8'h00;
    nextFlags = flags;
    writeRes  = 1'b0;
    taken     = 1'b0;
    skip      = 1'b0;
    target    = pcIn + PC_W'(1);
    cycles    = `EBSU_CYC_ONE;
    subB      = (req.op == OP_COMPARE_IMMEDIATE) ? req.opB : req.opB;
    cin       = (req.op == OP_COMPARE_WITH_CARRY) ? flags[`EBSU_FLAG_C] : 1'b0;
    diff      = {1'b0, req.opA} - {1'b0, subB} - {8'h00, cin};
    case (req.op)
      OP_SET_BITS_IMM: begin
        aluRes = req.opA | req.opB;
        writeRes = 1'b1;
        nextFlags = logicFlags(flags, aluRes);
      end
      OP_CLEAR_BITS_IMM: begin
        aluRes = req.opA & ~req.opB;
        writeRes = 1'b1;
        nextFlags = logicFlags(flags, aluRes);
      end
      OP_TEST_ZERO_MINUS: begin
        aluRes = req.opA & req.opA;
        nextFlags = logicFlags(flags, aluRes);
      end
      OP_RELATIVE_JUMP: begin
        taken = 1'b1;
        cycles = `EBSU_CYC_TWO;
      end
      OP_RELATIVE_SUBCALL: begin
        taken = 1'b1;
        cycles = `EBSU_CYC_THREE;
      end
      OP_POINTER_JUMP: begin
        target = zPointer[PC_W-1:0];
        cycles = `EBSU_CYC_TWO;
      end
      OP_POINTER_CALL: begin
        target = zPointer[PC_W-1:0];
        cycles = `EBSU_CYC_THREE;
      end
      OP_COMPARE_SKIP_EQUAL: skip = (req.opA == req.opB);
      OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
        aluRes = diff[7:0];
        nextFlags[`EBSU_FLAG_C] = diff[8];
        nextFlags[`EBSU_FLAG_N] = diff[7];
        nextFlags[`EBSU_FLAG_V] = (req.opA[7] & ~subB[7] & ~diff[7]) |
                                  (~req.opA[7] & subB[7] & diff[7]);
        nextFlags[`EBSU_FLAG_S] = nextFlags[`EBSU_FLAG_N] ^ nextFlags[`EBSU_FLAG_V];
        nextFlags[`EBSU_FLAG_H] = (~req.opA[3] & subB[3]) | (subB[3] & diff[3]) |
                                  (diff[3] & ~req.opA[3]);
        // Carry form keeps Z only when the result is zero, else clears it
        if (req.op == OP_COMPARE_WITH_CARRY)
          nextFlags[`EBSU_FLAG_Z] = (diff[7:0] == 8'h00) & flags[`EBSU_FLAG_Z];
        else
          nextFlags[`EBSU_FLAG_Z] = (diff[7:0] == 8'h00);
      end
      OP_SKIP_REG_BIT_CLEAR: skip = ~req.opA[req.bitSel];
      OP_SKIP_REG_BIT_SET:   skip = req.opA[req.bitSel];
      OP_SKIP_IO_BIT_CLEAR:  skip = ~req.ioValue[req.bitSel];
      OP_SKIP_IO_BIT_SET:    skip = req.ioValue[req.bitSel];
      // Named branches (signed, unsigned, H, T, V, I) map to these two with bitSel
      OP_BRANCH_FLAG_SET: begin
        taken = flags[req.bitSel];
        cycles = taken ? `EBSU_CYC_TWO : `EBSU_CYC_ONE;
      end
      OP_BRANCH_FLAG_CLEAR: begin
        taken = ~flags[req.bitSel];
        cycles = taken ? `EBSU_CYC_TWO : `EBSU_CYC_ONE;
      end
      OP_LOAD_INDIRECT, OP_LOAD_INDIRECT_INC: cycles = `EBSU_CYC_TWO;
      default: cycles = `EBSU_CYC_ONE;
    endcase
    if (taken)
      target = relTarget(pcIn, req.offset);
    if (skip) begin
      // Skipping a two-word instruction costs one more cycle
      target = pcIn + (req.nextIsTwoWord ? PC_W'(3) : PC_W'(2));
      cycles = req.nextIsTwoWord ? `EBSU_CYC_THREE : `EBSU_CYC_TWO;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  ebsu_state_t state;
  logic [1:0]  remain;
  ebsu_op_t    heldOp;
  logic        start;
  assign start = reqValid && (state == ST_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= ST_IDLE;
      remain <= 2'h0;
      heldOp <= OP_NOP;
      busy   <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (start && cycles != `EBSU_CYC_ONE) begin
          state  <= ST_WAIT;
          remain <= cycles - 2'h1;
          heldOp <= req.op;
          busy   <= 1'b1;
        end
        ST_WAIT: begin
          remain <= remain - 2'h1;
          if (remain == 2'h1) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Done marks the last cycle of every instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      done <= 1'b0;
    else
      done <= (start && cycles == `EBSU_CYC_ONE) || (state == ST_WAIT && remain == 2'h1);
  end

  // ----------------------------------------------------------------
  // Results, flags and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags       <= `EBSU_FLAGS_RST;
      result      <= 8'h00;
      resultWrite <= 1'b0;
    end else begin
      resultWrite <= 1'b0;
      if (start) begin
        flags <= nextFlags;
        if (writeRes) begin
          result      <= aluRes;
          resultWrite <= 1'b1;
        end
      end else if (state == ST_WAIT && remain == 2'h1 &&
                   (heldOp == OP_LOAD_INDIRECT || heldOp == OP_LOAD_INDIRECT_INC)) begin
        result      <= memData;
        resultWrite <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcOut      <= '0;
      pcLoad     <= 1'b0;
      pushReturn <= 1'b0;
    end else begin
      pcLoad     <= start;
      pushReturn <= start && (req.op == OP_RELATIVE_SUBCALL || req.op == OP_POINTER_CALL);
      if (start)
        pcOut <= target;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAddr <= 16'h0000;
      memRead <= 1'b0;
      xNext   <= 16'h0000;
      xWrite  <= 1'b0;
    end else begin
      memRead <= start && (req.op == OP_LOAD_INDIRECT || req.op == OP_LOAD_INDIRECT_INC);
      xWrite  <= start && (req.op == OP_LOAD_INDIRECT_INC);
      if (start) begin
        memAddr <= xPointer;
        xNext   <= xPointer + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  set_bits_or_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_SET_BITS_IMM |=> resultWrite && result == $past(req.opA | req.opB))
    else $error("set bits result wrong");
  clear_bits_and_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_CLEAR_BITS_IMM |=> result == $past(req.opA & ~req.opB))
    else $error("clear bits result wrong");
  test_no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_TEST_ZERO_MINUS |=> !resultWrite &&
      flags[`EBSU_FLAG_Z] == ($past(req.opA) == 8'h00))
    else $error("test altered register or Z wrong");
  rel_call_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_RELATIVE_SUBCALL |=> pushReturn ##0 !done ##1 !done ##1 done)
    else $error("relative call length wrong");
  ptr_jump_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_POINTER_JUMP |=> $stable(flags) && pcOut == $past(zPointer[PC_W-1:0]))
    else $error("pointer jump wrong");
  ptr_call_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_POINTER_CALL |=> busy [*2] ##1 !busy)
    else $error("pointer call length wrong");
  skip_equal_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_COMPARE_SKIP_EQUAL && req.opA == req.opB && !req.nextIsTwoWord
      |=> pcOut == $past(pcIn) + PC_W'(2) && $stable(flags))
    else $error("skip equal target wrong");
  compare_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_COMPARE_REGS |=> flags[`EBSU_FLAG_C] == ($past(req.opA) < $past(req.opB)))
    else $error("compare carry wrong");
  branch_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_BRANCH_FLAG_SET && !flags[req.bitSel] |=> done && !busy)
    else $error("untaken branch not one cycle");
  load_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.op == OP_LOAD_INDIRECT_INC |=> xWrite && xNext == $past(xPointer) + 16'h0001
      ##1 resultWrite && done)
    else $error("load post-increment wrong");
endmodule

// >>> bench/test_cpu_exec_branch_skip_unit.sv
// Self-checking bench for the execute, branch and skip unit
`timescale 1ns/10ps
module test_cpu_exec_branch_skip_unit;
  import ebsu_pkg::*;
  // ------
  // Signals
  // ------
  localparam int PC_W = 12;
  logic            clk, rst_n, reqValid;
  ebsu_req_t       req;
  logic [PC_W-1:0] pcIn, pcOut;
  logic [15:0]     zPointer, xPointer, memAddr, xNext, sAddr, sXn;
  logic [7:0]      memData, result, flags, model;
  logic            busy, done, pcLoad, pushReturn, resultWrite, memRead, xWrite;
  logic            sLoad, sPush, sRead, sXw, sWr, sBusy;
  int              n_mismatch, num_checks, ticks, cyc;

  ebsu_exec_unit #(.PC_W(PC_W)) uut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
    .req(req), .pcIn(pcIn), .zPointer(zPointer), .xPointer(xPointer), .memData(memData),
    .busy(busy), .done(done), .pcOut(pcOut), .pcLoad(pcLoad), .pushReturn(pushReturn),
    .result(result), .resultWrite(resultWrite), .flags(flags), .memAddr(memAddr),
    .memRead(memRead), .xNext(xNext), .xWrite(xWrite));

  // ------
  // Tasks
  // ------
  task automatic close_out;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string w, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask

  // Subtract flags; chained form can only keep or clear zero
  function automatic logic [7:0] cmpf(logic [7:0] a, b, logic ci, ch, logic [7:0] f);
    logic [7:0] r;
    logic       v;
    r = a - b - {7'h0, ci};
    v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    return {f[7:6], (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]), r[7] ^ v, v, r[7],
            (r == 8'h00) & (f[1] | ~ch), (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7])};
  endfunction

  function automatic logic [7:0] lf(logic [7:0] r, logic [7:0] f);
    return {f[7:5], r[7], 1'b0, r[7], r == 8'h00, f[0]};
  endfunction

  task automatic exec(ebsu_op_t op, logic [7:0] a, b, logic [2:0] bs, logic [11:0] k,
                      logic two);
    @(posedge clk);
    req <= '{op, a, b, b, bs, k, two};
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    {sLoad, sPush, sRead, sXw, sBusy} = {pcLoad, pushReturn, memRead, xWrite, busy};
    {sAddr, sXn} = {memAddr, xNext};
    cyc = 1;
    while (done !== 1'b1 && cyc < 6) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    sWr = resultWrite;
  endtask

  task automatic t_branch;
    logic tk;
    for (int s = 0; s < 16; s++) begin
      tk = model[s[2:0]] ^ s[3];
      exec(s[3] ? OP_BRANCH_FLAG_CLEAR : OP_BRANCH_FLAG_SET, 8'h00, 8'h00, s[2:0], 12'hff0, 1'b0);
      chk("br cycles", tk ? 16'h2 : 16'h1, cyc[15:0]);
      chk("br pc", tk ? 16'h0f1 : 16'h101, {4'h0, pcOut});
      chk("br flags", {8'h00, model}, {8'h00, flags});
    end
  endtask

  task automatic t_compare;
    ebsu_op_t   ops [6] = '{OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
                            OP_COMPARE_WITH_CARRY, OP_COMPARE_REGS, OP_COMPARE_IMMEDIATE};
    logic [7:0] av [6] = '{8'h10, 8'h30, 8'h08, 8'h05, 8'h10, 8'h80};
    logic [7:0] bv [6] = '{8'h20, 8'h30, 8'h08, 8'h05, 8'h01, 8'h01};
    logic       ch;
    for (int i = 0; i < 6; i++) begin
      ch = (ops[i] == OP_COMPARE_WITH_CARRY);
      exec(ops[i], av[i], bv[i], 3'h0, 12'h000, 1'b0);
      model = cmpf(av[i], bv[i], ch & model[0], ch, model);
      chk("cmp flags", {8'h00, model}, {8'h00, flags});
      chk("cmp cycles", 16'h1, cyc[15:0]);
      t_branch();
    end
  endtask

  task automatic lg(ebsu_op_t op, logic [7:0] a, b, r);
    exec(op, a, b, 3'h0, 12'h000, 1'b0);
    model = lf(r, model);
    chk("logic flags", {8'h00, model}, {8'h00, flags});
    chk("logic cycles", 16'h1, cyc[15:0]);
    if (op != OP_TEST_ZERO_MINUS) chk("logic result", {8'h01, r}, {7'h0, sWr, result});
    else chk("test write", 16'h0000, {15'h0, sWr});
  endtask

  task automatic jp(ebsu_op_t op, int n, logic push, logic [11:0] pc);
    exec(op, 8'h00, 8'h00, 3'h0, 12'h005, 1'b0);
    chk("jump cycles", n[15:0], cyc[15:0]);
    chk("jump pc", {3'h1, push, pc}, {2'h0, sLoad, sPush, pcOut});
    chk("jump flags", {8'h00, model}, {8'h00, flags});
    chk("jump busy", 16'h0002, {14'h0, sBusy, busy});
  endtask

  task automatic sk(ebsu_op_t op, logic [7:0] a, b, logic [2:0] bs, logic two, skp);
    exec(op, a, b, bs, 12'h000, two);
    chk("skip cycles", 16'(skp ? 2 + two : 1), cyc[15:0]);
    chk("skip pc", skp ? 16'h102 + two : 16'h101, {4'h0, pcOut});
    chk("skip flags", {8'h00, model}, {8'h00, flags});
  endtask

  task automatic ld(ebsu_op_t op, logic inc);
    exec(op, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0);
    chk("load addr", 16'h1234, sAddr);
    chk("load result", 16'h015a, {7'h0, sWr, result});
    chk("load cycles", 16'h2, cyc[15:0]);
    chk("load strobes", {15'h1, inc}, {14'h0, sRead, sXw});
    if (inc) chk("post inc", 16'h1235, sXn);
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {n_mismatch, num_checks, ticks} = '0;
    {rst_n, reqValid, model, pcIn} = {2'h0, 8'h00, 12'h100};
    req = '0;
    {zPointer, xPointer, memData} = {16'h0abc, 16'h1234, 8'h5a};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset flags", 16'h0000, {7'h0, done, flags});
    t_compare();
    lg(OP_SET_BITS_IMM, 8'h80, 8'h01, 8'h81);
    lg(OP_CLEAR_BITS_IMM, 8'h0f, 8'h0f, 8'h00);
    lg(OP_CLEAR_BITS_IMM, 8'hf5, 8'h05, 8'hf0);
    lg(OP_TEST_ZERO_MINUS, 8'h00, 8'h00, 8'h00);
    lg(OP_TEST_ZERO_MINUS, 8'hc3, 8'h00, 8'hc3);
    jp(OP_RELATIVE_JUMP, 2, 1'b0, 12'h106);
    jp(OP_RELATIVE_SUBCALL, 3, 1'b1, 12'h106);
    jp(OP_POINTER_JUMP, 2, 1'b0, 12'habc);
    jp(OP_POINTER_CALL, 3, 1'b1, 12'habc);
    sk(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 3'h0, 1'b0, 1'b1);
    sk(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5b, 3'h0, 1'b1, 1'b0);
    sk(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 3'h0, 1'b1, 1'b1);
    sk(OP_SKIP_REG_BIT_CLEAR, 8'hfe, 8'h01, 3'h0, 1'b1, 1'b1);
    sk(OP_SKIP_REG_BIT_CLEAR, 8'h80, 8'h7f, 3'h7, 1'b0, 1'b0);
    sk(OP_SKIP_REG_BIT_SET, 8'h80, 8'h7f, 3'h7, 1'b0, 1'b1);
    sk(OP_SKIP_REG_BIT_SET, 8'hfe, 8'h01, 3'h0, 1'b0, 1'b0);
    sk(OP_SKIP_IO_BIT_CLEAR, 8'h04, 8'hfb, 3'h2, 1'b0, 1'b1);
    sk(OP_SKIP_IO_BIT_CLEAR, 8'hfb, 8'h04, 3'h2, 1'b0, 1'b0);
    sk(OP_SKIP_IO_BIT_SET, 8'hbf, 8'h40, 3'h6, 1'b1, 1'b1);
    sk(OP_SKIP_IO_BIT_SET, 8'h40, 8'hbf, 3'h6, 1'b0, 1'b0);
    ld(OP_LOAD_INDIRECT, 1'b0);
    ld(OP_LOAD_INDIRECT_INC, 1'b1);
    close_out();
  end
endmodule
